// [core/osc_nco.sv]
// Phase-accumulator oscillator: emits a one-cycle tick at inc/2^W of the clock rate.
// Assumes a synchronous active-low reset and a caller that holds inc steady enough.
module osc_nco #(
    parameter int W = 24
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         enable,
    input  wire logic [W-1:0] inc,
    output logic              tick_q
);
    logic [W-1:0] acc_q;
    logic [W-1:0] acc_d;
    logic         tick_d;
    logic [W:0]   sum;

    always_comb begin
        sum    = {1'b0, acc_q} + {1'b0, inc};
        acc_d  = acc_q;
        tick_d = 1'b0;
        if (enable) begin
            acc_d  = sum[W-1:0];
            tick_d = sum[W];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            acc_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            acc_q  <= acc_d;
            tick_q <= tick_d;
        end
    end

    nco_idle_a: assert property (@(posedge clk) disable iff (!resetn)
        !enable |=> !tick_q && $stable(acc_q)) else $error("nco ticked while stopped");
endmodule

// [core/osc_pkg.sv]
// Constants, register map and carrier types for the oscillator select and trim block.
// Assumes one 250 MHz clock; every oscillator is modelled as a one-cycle enable rate.
package osc_pkg;

    // ----------------------------------------------------------------
    // Register map (index; byte address is four times the index)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [7:0] MAIN_TRIM_IDX = 8'hE8;
    localparam logic [7:0] LS_TRIM_IDX   = 8'hE9;
    localparam logic [7:0] CTRL_IDX      = 8'hE0;
    localparam logic [7:0] STATUS_IDX    = 8'hEA;
    localparam logic [7:0] XTAL_TRIM_IDX = 8'hEB;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_XTAL_EN_BIT = 7;
    localparam int CTRL_PLL_BIT     = 6;
    localparam int CTRL_CLR_BIT     = 5;
    localparam int CTRL_INTV_LSB    = 3;
    localparam int LS_DISABLE_BIT   = 6;
    localparam int LS_TRIM_W        = 6;
    localparam logic [7:0] CTRL_RESET      = 8'h00;
    localparam logic [7:0] MAIN_TRIM_5V0   = 8'h80;
    localparam logic [7:0] MAIN_TRIM_3V3   = 8'h80;
    localparam logic [5:0] LS_TRIM_FACTORY = 6'h20;
    localparam logic [7:0] XTAL_TRIM_FACT  = 8'h00;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ----------------------------------------------------------------
    // Rates and oscillator increments
    // ----------------------------------------------------------------
    localparam longint CLK_HZ   = 250_000_000;
    localparam longint MAIN_HZ  = 48_000_000;
    localparam longint LS_HZ    = 32_000;
    localparam longint XTAL_HZ  = 32_768;
    localparam int     NCO_W    = 24;
    localparam logic [NCO_W-1:0] MAIN_INC_CENTRE = NCO_W'((MAIN_HZ << NCO_W) / CLK_HZ);
    localparam logic [NCO_W-1:0] LS_INC_CENTRE   = NCO_W'((LS_HZ << NCO_W) / CLK_HZ);
    localparam logic [NCO_W-1:0] MAIN_TRIM_STEP  = 24'h00_1000;
    localparam logic [NCO_W-1:0] LS_TRIM_STEP    = 24'h00_0010;
    localparam int SLEEP_ONE_SEC_S     = 1;
    localparam int SLEEP_ONE_SEC_TICKS = int'(XTAL_HZ) * SLEEP_ONE_SEC_S;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic {SRC_LOW_SPEED, SRC_CRYSTAL} src_t;

    typedef struct packed {
        logic clk48;
        logic clk24;
        logic clk32k;
    } clk_en_t;

endpackage

// [core/osc_select_trim.sv]
// Oscillator select and trim: main oscillator enables, low-speed oscillator,
// crystal oscillator and the 32K source switch, with AXI4-Lite registers.
// Assumes crystal pin levels arrive synchronous to aclk.
module osc_select_trim
    import osc_pkg::*;
#(
    parameter logic [7:0] MAIN_TRIM_FACTORY = osc_pkg::MAIN_TRIM_5V0,
    parameter logic [5:0] LS_TRIM_FACT      = osc_pkg::LS_TRIM_FACTORY,
    parameter logic [7:0] XTAL_TRIM_FACTORY = osc_pkg::XTAL_TRIM_FACT,
    parameter int         SLEEP_ONE_SEC     = osc_pkg::SLEEP_ONE_SEC_TICKS
) (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [osc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [osc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire logic                      sleep_mode,
    input  wire logic                      crystal_input_pin,
    output logic                           crystal_output_pin_o,
    output logic                           crystal_output_pin_oe,
    output osc_pkg::clk_en_t               clk_en_q,
    output logic                           sleep_tc_q,
    output logic                           pll_lock_en_q,
    output logic                           low_speed_low_current_q,
    output logic [7:0]                     crystal_osc_trim_q
);
    import osc_pkg::*;

    localparam int CNT_W = $clog2(SLEEP_ONE_SEC) + 1;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic [NCO_W-1:0] trim_inc(input logic [NCO_W-1:0] centre,
                                                  input logic [NCO_W-1:0] step,
                                                  input logic [7:0] trim,
                                                  input logic [7:0] mid);
        return centre + NCO_W'(trim) * step - NCO_W'(mid) * step;
    endfunction

    // Interval select 3 is one second; each step below is eight times shorter
    function automatic logic [CNT_W-1:0] intv_ticks(input logic [1:0] sel);
        return CNT_W'(SLEEP_ONE_SEC >> (3 * (3 - int'(sel))));
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        return a == byte_addr(idx);
    endfunction

    // ----------------------------------------------------------------
    // Register bus slave
    // ----------------------------------------------------------------
    logic              aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [7:0]        wdata_q, wdata_d;
    logic              wlane_q, wlane_d;
    logic              awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
    logic [1:0]        bresp_d, rresp_d;
    logic [31:0]       rdata_d;
    logic [7:0]        main_trim_q, main_trim_d;
    logic [6:0]        ls_trim_q, ls_trim_d;
    logic [7:0]        ctrl_q, ctrl_d;
    logic [7:0]        xtal_trim_d;
    logic              do_write;
    src_t              src_q, src_d;
    logic [CNT_W-1:0]  cnt_q;

    assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;

    always_comb begin
        aw_hold_d   = aw_hold_q;
        w_hold_d    = w_hold_q;
        awaddr_d    = awaddr_q;
        wdata_d     = wdata_q;
        wlane_d     = wlane_q;
        bvalid_d    = s_axi_bvalid;
        bresp_d     = s_axi_bresp;
        rvalid_d    = s_axi_rvalid;
        rdata_d     = s_axi_rdata;
        rresp_d     = s_axi_rresp;
        main_trim_d = main_trim_q;
        ls_trim_d   = ls_trim_q;
        xtal_trim_d = crystal_osc_trim_q;
        ctrl_d      = ctrl_q;
        ctrl_d[CTRL_CLR_BIT] = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_d = 1'b1;
            wdata_d  = s_axi_wdata[7:0];
            wlane_d  = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (do_write) begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = RESP_OKAY;
            if (hit(awaddr_q, MAIN_TRIM_IDX)) begin
                if (wlane_q) main_trim_d = wdata_q;
            end else if (hit(awaddr_q, LS_TRIM_IDX)) begin
                if (wlane_q) ls_trim_d = wdata_q[6:0];
            end else if (hit(awaddr_q, CTRL_IDX)) begin
                if (wlane_q) ctrl_d = wdata_q;
            end else if (hit(awaddr_q, XTAL_TRIM_IDX)) begin
                if (wlane_q) xtal_trim_d = wdata_q;
            end else if (!hit(awaddr_q, STATUS_IDX)) begin
                bresp_d = RESP_SLVERR;
            end
        end
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            rdata_d  = 32'h0000_0000;
            // Main trim is write-only and reads as zero
            if (hit(s_axi_araddr, LS_TRIM_IDX)) begin
                rdata_d[6:0] = ls_trim_q;
            end else if (hit(s_axi_araddr, CTRL_IDX)) begin
                rdata_d[7:0] = {ctrl_q[7:6], 1'b0, ctrl_q[4:0]};
            end else if (hit(s_axi_araddr, STATUS_IDX)) begin
                rdata_d[CNT_W:0] = {cnt_q, src_q == SRC_CRYSTAL};
            end else if (hit(s_axi_araddr, XTAL_TRIM_IDX)) begin
                rdata_d[7:0] = crystal_osc_trim_q;
            end else if (!hit(s_axi_araddr, MAIN_TRIM_IDX)) begin
                rresp_d = RESP_SLVERR;
            end
        end
        awready_d = !aw_hold_d && !bvalid_d;
        wready_d  = !w_hold_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q          <= 1'b0;
            w_hold_q           <= 1'b0;
            awaddr_q           <= '0;
            wdata_q            <= 8'h00;
            wlane_q            <= 1'b0;
            s_axi_awready      <= 1'b0;
            s_axi_wready       <= 1'b0;
            s_axi_bvalid       <= 1'b0;
            s_axi_bresp        <= RESP_OKAY;
            s_axi_arready      <= 1'b0;
            s_axi_rvalid       <= 1'b0;
            s_axi_rdata        <= 32'h0000_0000;
            s_axi_rresp        <= RESP_OKAY;
            main_trim_q        <= MAIN_TRIM_FACTORY;
            ls_trim_q          <= {1'b0, LS_TRIM_FACT};
            ctrl_q             <= CTRL_RESET;
            crystal_osc_trim_q <= XTAL_TRIM_FACTORY;
        end else begin
            aw_hold_q          <= aw_hold_d;
            w_hold_q           <= w_hold_d;
            awaddr_q           <= awaddr_d;
            wdata_q            <= wdata_d;
            wlane_q            <= wlane_d;
            s_axi_awready      <= awready_d;
            s_axi_wready       <= wready_d;
            s_axi_bvalid       <= bvalid_d;
            s_axi_bresp        <= bresp_d;
            s_axi_arready      <= arready_d;
            s_axi_rvalid       <= rvalid_d;
            s_axi_rdata        <= rdata_d;
            s_axi_rresp        <= rresp_d;
            main_trim_q        <= main_trim_d;
            ls_trim_q          <= ls_trim_d;
            ctrl_q             <= ctrl_d;
            crystal_osc_trim_q <= xtal_trim_d;
        end
    end

    // ----------------------------------------------------------------
    // Oscillators
    // ----------------------------------------------------------------
    logic             main_tick, ls_tick, ls_run;
    logic [NCO_W-1:0] main_inc, ls_inc;

    assign main_inc = trim_inc(MAIN_INC_CENTRE, MAIN_TRIM_STEP, main_trim_q, 8'h80);
    // Low-current sleep state drops the trim, so accuracy suffers
    assign ls_inc = sleep_mode ? LS_INC_CENTRE
                  : trim_inc(LS_INC_CENTRE, LS_TRIM_STEP, {2'b00, ls_trim_q[5:0]}, 8'h20);
    assign ls_run = !ls_trim_q[LS_DISABLE_BIT];

    osc_nco #(.W(NCO_W)) main_osc (
        .clk    (aclk),
        .resetn (aresetn),
        .enable (1'b1),
        .inc    (main_inc),
        .tick_q (main_tick)
    );

    osc_nco #(.W(NCO_W)) low_speed_osc (
        .clk    (aclk),
        .resetn (aresetn),
        .enable (ls_run),
        .inc    (ls_inc),
        .tick_q (ls_tick)
    );

    // ----------------------------------------------------------------
    // Crystal, sleep timer and 32K source switch
    // ----------------------------------------------------------------
    logic             xin_q, xin_d, half_q, half_d, xt_tick, tc_d, xtal_en;
    logic [CNT_W-1:0] cnt_d;
    clk_en_t          clk_en_d;

    assign xtal_en = ctrl_q[CTRL_XTAL_EN_BIT];
    assign xt_tick = xtal_en && crystal_input_pin && !xin_q;

    always_comb begin
        xin_d    = crystal_input_pin;
        half_d   = main_tick ? !half_q : half_q;
        clk_en_d.clk48  = main_tick;
        clk_en_d.clk24  = main_tick && half_q;
        // Both sources are single-cycle pulses, so a switch cannot split one
        clk_en_d.clk32k = (src_q == SRC_CRYSTAL) ? xt_tick : ls_tick;
        cnt_d = cnt_q;
        tc_d  = 1'b0;
        if (ctrl_q[CTRL_CLR_BIT]) begin
            cnt_d = '0;
        end else if (clk_en_q.clk32k) begin
            if (cnt_q >= intv_ticks(ctrl_q[CTRL_INTV_LSB +: 2]) - CNT_W'(1)) begin
                cnt_d = '0;
                tc_d  = 1'b1;
            end else begin
                cnt_d = cnt_q + CNT_W'(1);
            end
        end
        // Terminal count alone moves the source; no interrupt enable gates it
        src_d = src_q;
        if (sleep_tc_q) begin
            src_d = xtal_en ? SRC_CRYSTAL : SRC_LOW_SPEED;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xin_q                   <= 1'b0;
            half_q                  <= 1'b0;
            cnt_q                   <= '0;
            sleep_tc_q              <= 1'b0;
            src_q                   <= SRC_LOW_SPEED;
            clk_en_q                <= '0;
            pll_lock_en_q           <= 1'b0;
            low_speed_low_current_q <= 1'b0;
            crystal_output_pin_o    <= 1'b0;
            crystal_output_pin_oe   <= 1'b0;
        end else begin
            xin_q                   <= xin_d;
            half_q                  <= half_d;
            cnt_q                   <= cnt_d;
            sleep_tc_q              <= tc_d;
            src_q                   <= src_d;
            clk_en_q                <= clk_en_d;
            pll_lock_en_q           <= ctrl_q[CTRL_PLL_BIT] && src_q == SRC_CRYSTAL;
            low_speed_low_current_q <= sleep_mode;
            crystal_output_pin_o    <= !crystal_input_pin;
            crystal_output_pin_oe   <= xtal_en;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence tc_seen;
        sleep_tc_q;
    endsequence

    sequence src_moved;
        $changed(src_q);
    endsequence

    property switch_on_tc;
        @(posedge aclk) disable iff (!aresetn) tc_seen ##0 xtal_en |=> src_q == SRC_CRYSTAL;
    endproperty

    property moved_only_at_tc;
        @(posedge aclk) disable iff (!aresetn) src_moved |-> $past(sleep_tc_q);
    endproperty

    clk24_pair_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en_q.clk24 |-> clk_en_q.clk48 ##1 !clk_en_q.clk24) else $error("bad 24 MHz pulse");
    trim_reset_a: assert property (@(posedge aclk)
        $rose(aresetn) |-> main_trim_q == MAIN_TRIM_FACTORY) else $error("main trim not reset");
    trim_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && wlane_q && hit(awaddr_q, MAIN_TRIM_IDX) |=> main_trim_q == $past(wdata_q))
        else $error("main trim write lost");
    ls_reset_a: assert property (@(posedge aclk)
        $rose(aresetn) |-> ls_trim_q == {1'b0, LS_TRIM_FACT}) else $error("low trim not reset");
    ls_stopped_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ls_trim_q[LS_DISABLE_BIT] [*3] |-> !ls_tick) else $error("stopped oscillator ticked");
    low_current_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sleep_mode |=> low_speed_low_current_q) else $error("sleep state missed");
    xtal_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !xtal_en |=> !crystal_output_pin_oe) else $error("crystal driven while off");
    src_reset_a: assert property (@(posedge aclk)
        $rose(aresetn) |-> src_q == SRC_LOW_SPEED) else $error("wrong source after reset");
    switch_tc_a: assert property (switch_on_tc) else $error("no switch at terminal count");
    switch_edge_a: assert property (moved_only_at_tc) else $error("source moved off tc");
    pulse_src_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en_q.clk32k |-> $past(src_q == SRC_CRYSTAL ? xt_tick : ls_tick))
        else $error("32K pulse from wrong source");
endmodule

// [tb/oscillator_select_trim_tb_top.sv]
// Bench for the oscillator select and trim block over AXI4-Lite.
// Assumes a shortened one second of two low-speed ticks, so interval 3 fits the run.
module oscillator_select_trim_tb_top;
    import osc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bv, br = 0, arv = 0, rv, rr = 0;
    logic awr, wr, arr, sleep_mode = 0, xin, xo, xoe, tc, pll, lowc;
    logic [11:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rd_q;
    logic [1:0]  bresp, rresp;
    logic [7:0]  xtrim;
    clk_en_t     clk_en;
    int fails = 0, checks = 0;
    always #2 aclk = ~aclk;
    osc_select_trim #(.SLEEP_ONE_SEC(2)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd_q), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .sleep_mode(sleep_mode), .crystal_input_pin(xin),
        .crystal_output_pin_o(xo), .crystal_output_pin_oe(xoe), .clk_en_q(clk_en),
        .sleep_tc_q(tc), .pll_lock_en_q(pll), .low_speed_low_current_q(lowc),
        .crystal_osc_trim_q(xtrim));
    xtal_model xtal_u (.aclk(aclk), .drive_oe(xoe), .xin(xin));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            fails++;
        end
    endtask
    task automatic complete_run();
        if (fails == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Each channel released at its own handshake edge
    task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d);
        awa <= {2'b00, idx, 2'b00};
        wd <= {24'h0, d};
        awv <= 1;
        wv <= 1;
        br <= 1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 0;
            if (wr) wv <= 0;
        end while (!bv);
        br <= 0;
        chk("bresp", 32'(RESP_OKAY), 32'(bresp));
        @(posedge aclk);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [31:0] exp,
                          input logic [1:0] er);
        ara <= {2'b00, idx, 2'b00};
        arv <= 1;
        rr <= 1;
        do begin
            @(posedge aclk);
            if (arr) arv <= 0;
        end while (!rv);
        rr <= 0;
        chk(nm, exp, rd_q);
        chk("rresp", 32'(er), 32'(rresp));
        @(posedge aclk);
    endtask
    // Source bit only; the counter field moves with the 32K ticks of whichever source is selected
    task automatic rd_src(input string nm, input logic exp);
        ara <= {2'b00, STATUS_IDX, 2'b00};
        arv <= 1;
        rr <= 1;
        do begin
            @(posedge aclk);
            if (arr) arv <= 0;
        end while (!rv);
        rr <= 0;
        chk(nm, 32'(exp), 32'(rd_q[0]));
        chk("rresp", 32'(RESP_OKAY), 32'(rresp));
        @(posedge aclk);
    endtask
    task automatic count48(input int n, output int c48, output int c24);
        c48 = 0;
        c24 = 0;
        repeat (n) begin
            @(posedge aclk);
            c48 += int'(clk_en.clk48);
            c24 += int'(clk_en.clk24);
        end
    endtask
    // Sel 0 watches the 32K enable, 1 the terminal count
    task automatic seen_in(input int n, input bit sel, output bit seen);
        seen = 0;
        repeat (n) begin
            @(posedge aclk);
            if ((sel ? tc : clk_en.clk32k) === 1'b1) seen = 1;
        end
    endtask
    initial begin
        int a, b, c, d;
        bit s;
        logic px;
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        rd_chk("ls_trim", LS_TRIM_IDX, 32'h0000_0020, RESP_OKAY);
        rd_chk("main_trim", MAIN_TRIM_IDX, 32'h0000_0000, RESP_OKAY);
        rd_chk("ctrl", CTRL_IDX, 32'h0000_0000, RESP_OKAY);
        rd_chk("status", STATUS_IDX, 32'h0000_0000, RESP_OKAY);
        rd_chk("xtal_trim", XTAL_TRIM_IDX, 32'h0000_0000, RESP_OKAY);
        chk("xtal_trim_out", 32'(XTAL_TRIM_FACT), 32'(xtrim));
        rd_chk("unmapped", 8'h10, 32'h0000_0000, RESP_SLVERR);
        chk("pin_oe", 0, 32'(xoe));
        count48(1000, a, b);
        chk("clk48_near", 1, 32'(a >= 191 && a <= 193));
        chk("clk24_half", 1, 32'(b >= a / 2 - 1 && b <= a / 2 + 1));
        axi_wr(MAIN_TRIM_IDX, 8'hFF);
        count48(1000, c, d);
        axi_wr(MAIN_TRIM_IDX, 8'h00);
        count48(1000, d, b);
        chk("trim_slope", 1, 32'(c > a && a > d));
        axi_wr(LS_TRIM_IDX, 8'hFF);
        rd_chk("ls_dis", LS_TRIM_IDX, 32'h0000_007F, RESP_OKAY);
        seen_in(16000, 0, s);
        chk("ls_stopped", 0, 32'(s));
        axi_wr(LS_TRIM_IDX, 8'h20);
        seen_in(16000, 0, s);
        chk("ls_running", 1, 32'(s));
        sleep_mode <= 1;
        repeat (2) @(posedge aclk);
        chk("low_current", 1, 32'(lowc));
        sleep_mode <= 0;
        axi_wr(CTRL_IDX, 8'h98);
        axi_wr(CTRL_IDX, 8'hB8);
        chk("pin_oe_on", 1, 32'(xoe));
        @(posedge aclk);
        px = xin;
        @(posedge aclk);
        chk("pin_out", 32'(!px), 32'(xo));
        rd_src("still_ls", 1'b0);
        seen_in(20000, 1, s);
        chk("tc_seen", 1, 32'(s));
        axi_wr(CTRL_IDX, 8'hD8);
        rd_src("src_xtal", 1'b1);
        chk("pll_on", 1, 32'(pll));
        complete_run();
    end
    initial begin
        repeat (90000) @(posedge aclk);
        fails++;
        complete_run();
    end
endmodule

// [tb/xtal_model.sv]
// Watch crystal model on the crystal pins.
// Assumes the design's pin output enable marks when the amplifier drives the crystal.
module xtal_model #(
    parameter int HALF = 3815
) (
    input  wire logic aclk,
    input  wire logic drive_oe,
    output logic      xin
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial xin = 1'b0;
    // Oscillates only while driven; a dead crystal holds its level
    always @(posedge aclk) begin
        if (drive_oe) begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) xin <= ~xin;
        end
    end
endmodule
